// file: rtl/lcl_defines.svh
// constants of the column data loader: widths, counts, cascade delays
// assumes inclusion by bare name from the loader and fifo files
`ifndef LCL_DEFINES_SVH
`define LCL_DEFINES_SVH

`define LCL_LANE_W            6
`define LCL_LANES             3
`define LCL_WORD_W            18
`define LCL_GROUPS            103
`define LCL_GROUP_W           7
`define LCL_FIRST_GROUP_R     7'h00
`define LCL_FIRST_GROUP_L     7'h66
`define LCL_SKIP_BELOW        7'h31
`define LCL_SKIP_ABOVE        7'h35
`define LCL_CASCADE_DELAY_300 7'h64
`define LCL_CASCADE_DELAY_309 7'h67
`define LCL_FIFO_DEPTH        16
`define LCL_SYNC_W            25

`endif

// file: rtl/lcl_pkg.sv
// types shared by the column data loader
// assumes lcl_defines.svh is on the include path
`include "lcl_defines.svh"

package lcl_pkg;

  typedef enum logic [2:0] {
    LCL_ST_WAIT_STB = 3'h1,
    LCL_ST_IDLE     = 3'h2,
    LCL_ST_SHIFT    = 3'h4
  } lcl_state_e;

  typedef logic [`LCL_GROUP_W-1:0] lcl_group_t;

endpackage : lcl_pkg

// file: rtl/lcl_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
`include "lcl_defines.svh"

module lcl_fifo
  import lcl_pkg::*;
#(
  parameter int WIDTH = 25,
  parameter int DEPTH = `LCL_FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_push;
  logic             do_pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

endmodule : lcl_fifo

// file: rtl/lcl_column_loader.sv
// column data loader: captures 18-bit gray words per shift clock into column
// positions, cascades the start pulse and latches the row on the strobe
// assumes all pin inputs are asynchronous to core_clk and the shift clock
// runs well below half the core clock; bidirectional pins resolved outside
//
// Summary of operation
// [RQ1] each shift clock delivers three 6-bit gray values as one 18-bit word
// [RQ2] right shift: lane 0,1,2 go to outputs 1,2,3, repeating to 309
// [RQ3] left shift keeps the same lane-to-output assignment as right shift
// [RQ4] controller keeps the start pulse low two shift clocks between pulses
// [RQ5] cascade start output rises 100 clocks (300 mode) or 103 clocks after start
// [RQ6] controller may clock up to 55 MHz; device must keep up
// [RQ7] data word captured on shift clock rising edge at selected column position
// [RQ8] strobe rise copies data register to outputs, clears shift; first strobe arms
// [RQ9] invert high stores inverted gray values, low stores them unchanged
// [RQ10] direction high: start on right pin, fill upward, drive left pin; else mirrored
// [RQ11] 300-output mode skips outputs 151 to 159, so a row takes 100 clocks
`include "lcl_defines.svh"

module lcl_column_loader
  import lcl_pkg::*;
#(
  parameter int FIFO_DEPTH = `LCL_FIFO_DEPTH
) (
  input  wire logic                                   core_clk,
  input  wire logic                                   reset,
  input  wire logic                                   shift_clk,
  input  wire logic [`LCL_LANE_W-1:0]                 lane0_gray_value,
  input  wire logic [`LCL_LANE_W-1:0]                 lane1_gray_value,
  input  wire logic [`LCL_LANE_W-1:0]                 lane2_gray_value,
  input  wire logic                                   direction_select,
  input  wire logic                                   output_count_select,
  input  wire logic                                   data_invert,
  input  wire logic                                   latch_strobe,
  input  wire logic                                   right_start_pulse_in,
  output logic                                        right_start_pulse_out,
  output logic                                        right_start_pulse_oe,
  input  wire logic                                   left_start_pulse_in,
  output logic                                        left_start_pulse_out,
  output logic                                        left_start_pulse_oe,
  output logic [`LCL_GROUPS*`LCL_WORD_W-1:0]          column_level,
  output logic                                        fifo_overrun
);

  localparam int FW = `LCL_GROUP_W + `LCL_WORD_W;

  // two-stage synchronisers; only stage two is read by logic
  logic [`LCL_SYNC_W-1:0] sync1;
  logic [`LCL_SYNC_W-1:0] sync2;
  logic                   clk_prev;
  logic                   stb_prev;
  logic [1:0]             sync_fill;

  logic                   s_clk;
  logic [`LCL_WORD_W-1:0] s_word;
  logic                   s_dir;
  logic                   s_mode300;
  logic                   s_inv;
  logic                   s_stb;
  logic                   s_rsp;
  logic                   s_lsp;

  logic                   shift_edge;
  logic                   strobe_edge;
  logic                   start_in;
  logic [`LCL_GROUP_W-1:0] row_limit;
  logic                   last_edge;

  lcl_state_e             state;
  logic [`LCL_GROUP_W-1:0] cnt;
  lcl_group_t             group;
  lcl_group_t             next_group;

  logic                   push_valid;
  logic                   push_ready;
  logic [FW-1:0]          push_data;
  logic                   pop_valid;
  logic                   pop_ready;
  logic [FW-1:0]          pop_data;
  lcl_group_t             pop_group;
  logic [`LCL_WORD_W-1:0] pop_word;

  logic [`LCL_WORD_W-1:0] col [`LCL_GROUPS];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {shift_clk, lane2_gray_value, lane1_gray_value, lane0_gray_value,
                direction_select, output_count_select, data_invert, latch_strobe,
                right_start_pulse_in, left_start_pulse_in};
      sync2 <= sync1;
    end
  end

  assign s_clk     = sync2[24];
  assign s_word    = sync2[23:6];
  assign s_dir     = sync2[5];
  assign s_mode300 = sync2[4];
  assign s_inv     = sync2[3];
  assign s_stb     = sync2[2];
  assign s_rsp     = sync2[1];
  assign s_lsp     = sync2[0];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clk_prev <= 1'b0;
      stb_prev <= 1'b0;
    end else begin
      clk_prev <= s_clk;
      stb_prev <= s_stb;
    end
  end

  // sync2 reads as left shift until it holds real pin levels, so keep both start pins released until then
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync_fill <= 2'h0;
    end else begin
      sync_fill <= {sync_fill[0], 1'b1};
    end
  end

  // edge rate is bounded by the core clock, so fast shift clocks need a faster core
  assign shift_edge  = s_clk & ~clk_prev; // [RQ6] [RQ7]
  assign strobe_edge = s_stb & ~stb_prev; // [RQ8]
  assign start_in    = s_dir ? s_rsp : s_lsp; // [RQ10]
  assign row_limit   = s_mode300 ? `LCL_CASCADE_DELAY_300 : `LCL_CASCADE_DELAY_309; // [RQ5]
  assign last_edge   = (state == LCL_ST_SHIFT) && shift_edge && (cnt == row_limit);

  // step across the gap of unused outputs in 300 mode
  always_comb begin
    if (s_dir) begin
      next_group = (s_mode300 && group == `LCL_SKIP_BELOW) ? `LCL_SKIP_ABOVE : group + 1'b1; // [RQ10] [RQ11]
    end else begin
      next_group = (s_mode300 && group == `LCL_SKIP_ABOVE) ? `LCL_SKIP_BELOW : group - 1'b1; // [RQ10] [RQ11]
    end
  end

  // nothing is shifted until the first strobe after reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= LCL_ST_WAIT_STB;
    end else begin
      case (state)
        LCL_ST_WAIT_STB: begin
          if (strobe_edge) begin
            state <= LCL_ST_IDLE; // [RQ8]
          end
        end
        LCL_ST_IDLE: begin
          if (!strobe_edge && shift_edge && start_in) begin
            state <= LCL_ST_SHIFT;
          end
        end
        LCL_ST_SHIFT: begin
          if (strobe_edge || last_edge) begin
            state <= LCL_ST_IDLE; // [RQ8] [RQ5]
          end
        end
        default: begin
          state <= LCL_ST_WAIT_STB;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt   <= '0;
      group <= '0;
    end else if (strobe_edge) begin
      cnt   <= '0; // [RQ8]
      group <= '0;
    end else if (state == LCL_ST_IDLE && shift_edge && start_in) begin
      cnt   <= `LCL_GROUP_W'(1);
      group <= s_dir ? `LCL_FIRST_GROUP_R : `LCL_FIRST_GROUP_L; // [RQ10]
    end else if (state == LCL_ST_SHIFT && shift_edge) begin
      cnt   <= cnt + 1'b1;
      group <= next_group;
    end
  end

  // lane order inside a group never depends on direction
  assign push_valid = (state == LCL_ST_SHIFT) && shift_edge && !strobe_edge; // [RQ7]
  assign push_data  = {group, s_word ^ {`LCL_WORD_W{s_inv}}}; // [RQ1] [RQ9] [RQ2] [RQ3]

  // cascade pulse stands from the last edge of the row to the next shift or strobe edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      right_start_pulse_out <= 1'b0;
      left_start_pulse_out  <= 1'b0;
      right_start_pulse_oe  <= 1'b0;
      left_start_pulse_oe   <= 1'b0;
    end else begin
      right_start_pulse_oe <= sync_fill[1] & ~s_dir; // [RQ10]
      left_start_pulse_oe  <= sync_fill[1] & s_dir; // [RQ10]
      if (shift_edge || strobe_edge) begin
        right_start_pulse_out <= last_edge & ~s_dir; // [RQ5] [RQ10]
        left_start_pulse_out  <= last_edge & s_dir; // [RQ5] [RQ10]
      end
    end
  end

  // a full fifo drops the word and flags it until the next strobe; set wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fifo_overrun <= 1'b0;
    end else if (push_valid && !push_ready) begin
      fifo_overrun <= 1'b1;
    end else if (strobe_edge) begin
      fifo_overrun <= 1'b0;
    end
  end

  // drain pauses in the copy cycle so the latched row is never torn
  assign pop_ready = ~strobe_edge;
  assign pop_group = pop_data[FW-1:`LCL_WORD_W];
  assign pop_word  = pop_data[`LCL_WORD_W-1:0];

  lcl_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) lcl_fifo_inst (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  genvar g;
  generate
    for (g = 0; g < `LCL_GROUPS; g++) begin : gen_col
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          col[g] <= '0;
        end else if (pop_valid && pop_ready && pop_group == `LCL_GROUP_W'(g)) begin
          col[g] <= pop_word; // [RQ7] [RQ2] [RQ3]
        end
      end

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          column_level[g*`LCL_WORD_W +: `LCL_WORD_W] <= '0;
        end else if (strobe_edge) begin
          column_level[g*`LCL_WORD_W +: `LCL_WORD_W] <= col[g]; // [RQ8]
        end
      end
    end
  endgenerate

endmodule : lcl_column_loader

// file: verif/lcl_column_loader_props.sv
// pin-level checks of the column data loader
// assumes a bind onto lcl_column_loader, one core clock domain
`include "lcl_defines.svh"

module lcl_column_loader_props
  import lcl_pkg::*;
#(
  parameter int FIFO_DEPTH = `LCL_FIFO_DEPTH
) (
  input wire logic                                   core_clk,
  input wire logic                                   reset,
  input wire logic                                   shift_clk,
  input wire logic                                   latch_strobe,
  input wire logic                                   direction_select,
  input wire logic                                   right_start_pulse_out,
  input wire logic                                   right_start_pulse_oe,
  input wire logic                                   left_start_pulse_out,
  input wire logic                                   left_start_pulse_oe,
  input wire logic [`LCL_GROUPS*`LCL_WORD_W-1:0]     column_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_oe_one_side: assert property (!(right_start_pulse_oe && left_start_pulse_oe))
    else $error("both start pins driven");
  // five cycles cover the input synchroniser latency
  a_oe_left_dir: assert property (direction_select [*5] |-> left_start_pulse_oe && !right_start_pulse_oe)
    else $error("left start pin not driven in right shift");
  a_oe_right_dir: assert property (!direction_select [*5] |-> right_start_pulse_oe && !left_start_pulse_oe)
    else $error("right start pin not driven in left shift");
  a_left_out_driven: assert property (left_start_pulse_out |-> left_start_pulse_oe)
    else $error("left cascade pulse on undriven pin");
  a_right_out_driven: assert property (right_start_pulse_out |-> right_start_pulse_oe)
    else $error("right cascade pulse on undriven pin");
  a_cascade_ends: assert property ((left_start_pulse_out || right_start_pulse_out) && $rose(shift_clk)
    |-> ##[1:5] !(left_start_pulse_out || right_start_pulse_out))
    else $error("cascade pulse outlives next shift clock");
  a_cascade_on_edge: assert property ($rose(left_start_pulse_out || right_start_pulse_out)
    |-> $past(shift_clk, 2))
    else $error("cascade pulse without shift clock");
  a_row_on_strobe: assert property (!$stable(column_level) |-> $past(latch_strobe, 2))
    else $error("column levels changed without strobe");

  c_left_cascade: cover property ($rose(left_start_pulse_out));
  c_right_cascade: cover property ($rose(right_start_pulse_out));
  c_row_latched: cover property (!$stable(column_level));
endmodule : lcl_column_loader_props

// file: verif/lcl_panel_ctrl.sv
// timing controller model: shift clock, gray words, start and strobe
// assumes callers enter its tasks at a rising core clock edge
module lcl_panel_ctrl
  import lcl_pkg::*;
(
  input wire logic    core_clk,
  output logic        shift_clk,
  output logic [17:0] word,
  output logic        data_invert,
  output logic        latch_strobe,
  output logic        start_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    shift_clk = 1'b0;
    word = 18'h00000;
    data_invert = 1'b0;
    latch_strobe = 1'b0;
    start_pulse = 1'b0;
  end

  // low phase of gap cycles lets callers run prompt or slow shift clocks
  task automatic shift_edge(input logic [17:0] w, input logic iv, input logic st, input int gap);
    word <= w;
    data_invert <= iv;
    start_pulse <= st;
    repeat (gap) @(posedge core_clk);
    shift_clk <= 1'b1;
    repeat (4) @(posedge core_clk);
    shift_clk <= 1'b0;
  endtask : shift_edge

  // two idle shift clocks first, so the last word is drained; the device must not take their words
  task automatic strobe();
    shift_edge(18'h3FFFF, 1'b0, 1'b0, 3);
    shift_edge(18'h3FFFF, 1'b0, 1'b0, 3);
    repeat (16) @(posedge core_clk);
    latch_strobe <= 1'b1;
    repeat (4) @(posedge core_clk);
    latch_strobe <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : strobe
endmodule : lcl_panel_ctrl

// file: verif/lcl_column_loader_tb_top.sv
// self-checking bench of the column data loader
// assumes design files, checker and lcl_panel_ctrl compiled first
`include "lcl_defines.svh"

module lcl_column_loader_tb_top
  import lcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CW = `LCL_GROUPS * `LCL_WORD_W;
  logic core_clk, reset, shift_clk, data_invert, latch_strobe, start_pulse;
  logic direction_select, output_count_select, fifo_overrun, right_pin, left_pin;
  logic right_start_pulse_out, right_start_pulse_oe, left_start_pulse_out, left_start_pulse_oe;
  logic [17:0]   word;
  logic [CW-1:0] column_level, exp_row;
  logic [CW-1:0] exp_q[$];
  int            n_errors, n_checks, seed;

  // no pull on the start pins: the controller drives low when not starting
  assign right_pin = right_start_pulse_oe ? right_start_pulse_out : (direction_select & start_pulse);
  assign left_pin = left_start_pulse_oe ? left_start_pulse_out : (!direction_select & start_pulse);

  lcl_column_loader lcl_column_loader_inst (
    .core_clk, .reset, .shift_clk,
    .lane0_gray_value(word[5:0]), .lane1_gray_value(word[11:6]), .lane2_gray_value(word[17:12]),
    .direction_select, .output_count_select, .data_invert, .latch_strobe,
    .right_start_pulse_in(right_pin), .right_start_pulse_out, .right_start_pulse_oe,
    .left_start_pulse_in(left_pin), .left_start_pulse_out, .left_start_pulse_oe,
    .column_level, .fifo_overrun
  );
  lcl_panel_ctrl lcl_panel_ctrl_inst (.core_clk, .shift_clk, .word, .data_invert, .latch_strobe, .start_pulse);

  always #20 core_clk = ~core_clk;

  task automatic chk(input logic [CW-1:0] got, input logic [CW-1:0] want);
    n_checks++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // one start edge, then a full row; cascade looked at after every word
  task automatic run_row(input logic d, input logic m, input logic armed);
    int n;
    int g;
    logic [17:0] w;
    logic iv;
    n = m ? 100 : 103;
    direction_select <= d;
    output_count_select <= m;
    repeat (8) @(posedge core_clk);
    lcl_panel_ctrl_inst.shift_edge(18'h00000, 1'b0, 1'b1, 4);
    for (int i = 0; i < n; i++) begin
      w = 18'($random(seed));
      iv = 1'($random(seed));
      g = (m && i >= 50) ? i + 3 : i;
      if (!d) g = `LCL_GROUPS - 1 - g;
      if (armed) exp_row[g*18 +: 18] = iv ? ~w : w;
      lcl_panel_ctrl_inst.shift_edge(w, iv, 1'b0, 3 + int'($unsigned($random(seed)) % 3));
      @(negedge core_clk);
      chk(CW'(d ? left_pin : right_pin), CW'(armed && i == n - 1));
      @(posedge core_clk);
    end
  endtask : run_row

  // the row expectation is queued before the strobe that latches it
  initial begin
    forever begin
      @(posedge latch_strobe);
      repeat (6) @(posedge core_clk);
      chk(column_level, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    seed = 32'h25C4;
    direction_select = 1'b1;
    output_count_select = 1'b0;
    exp_row = '0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    run_row(1'b1, 1'b0, 1'b0);
    exp_q.push_back(exp_row);
    lcl_panel_ctrl_inst.strobe();
    for (int k = 0; k < 4; k++) begin
      run_row(k[0], k[1], 1'b1);
      exp_q.push_back(exp_row);
      chk(CW'(fifo_overrun), '0);
      lcl_panel_ctrl_inst.strobe();
      $display("row done: direction %0d, 300-mode %0d", k[0], k[1]);
    end
    tally_and_finish();
  end
endmodule : lcl_column_loader_tb_top

bind lcl_column_loader lcl_column_loader_props #(.FIFO_DEPTH(FIFO_DEPTH)) lcl_column_loader_props_inst (
  .core_clk, .reset, .shift_clk, .latch_strobe, .direction_select,
  .right_start_pulse_out, .right_start_pulse_oe, .left_start_pulse_out, .left_start_pulse_oe, .column_level
);
